// ---- common/psl_regs.svh ----
// Constants of the power status indicator block.
// Assumes inclusion by bare name from any file of the block.
`ifndef PSL_REGS_SVH
`define PSL_REGS_SVH

// ----------------------------------------
// Timing
// ----------------------------------------
`define PSL_CLK_HZ         10000000
`define PSL_MS_PER_S       1000
`define PSL_HALF_MS        500
`define PSL_START_MS       2000
`define PSL_ONE_MS         1000
`define PSL_ZERO_MS        500
`define PSL_GAP_MS         500
`define PSL_FLASH_PERIOD   4
`define PSL_FLASH_REPEAT   4

// ----------------------------------------
// Fault conditions and codes
// ----------------------------------------
`define PSL_CODE_BITS      8
`define PSL_NUM_FAULTS     33
`define PSL_IDX_BAT1       5
`define PSL_IDX_BAT2       10
`define PSL_IDX_STBY_ON    15
`define PSL_IDX_STBY_BOOT  16
`define PSL_IDX_FIVE       17
`define PSL_IDX_THREE      23
`define PSL_IDX_CORE0      29
`define PSL_DCIN_BASE      8'h10
`define PSL_DCIN_LAST      8'h1f
`define PSL_BAT1_BASE      8'h21
`define PSL_BAT2_BASE      8'h31
`define PSL_STBY_ON_CODE   8'h40
`define PSL_STBY_BOOT_CODE 8'h45
`define PSL_FIVE_BASE      8'h50
`define PSL_THREE_BASE     8'h60
`define PSL_CORE0_BASE     8'h70
`define PSL_CORE0_LAST     8'h73
`define PSL_RSVD_BAT1      8'h20
`define PSL_RSVD_BAT2      8'h30
`define PSL_NO_CODE        8'h00

`endif

// ---- common/psl_pkg.sv ----
// Types of the power status indicator block.
// Assumes nothing beyond a SystemVerilog compiler.
package psl_pkg;

	// ----------------------------------------
	// Fault code frame sequencer
	// ----------------------------------------
	typedef enum logic [1:0] {
		blk_idle,
		blk_start,
		blk_bit_on,
		blk_bit_gap
	} psl_blink_state_t;

	// ----------------------------------------
	// Battery indicator modes
	// ----------------------------------------
	typedef enum logic [2:0] {
		bat_dark,
		bat_orange,
		bat_green,
		bat_blink,
		bat_flash
	} psl_bat_mode_t;

endpackage

// ---- common/psl_blink_if.sv ----
// Link between the status controller and the fault code blinker.
// Assumes both ends share one clock.
`timescale 1ns/10ps

interface psl_blink_if;
	logic       run;
	logic [7:0] code;
	logic       led_on;

	modport ctrl
	(
		output run,
		output code,
		input  led_on
	);

	modport blink
	(
		input  run,
		input  code,
		output led_on
	);
endinterface

// ---- hdl/psl_code_blinker.sv ----
// Fault code blinker: start gap, then eight pulse-width coded bits.
// Assumes a synchronous reset copy and a steady run level.
`timescale 1ns/10ps
`include "psl_regs.svh"

module psl_code_blinker #(
	parameter int unsigned HALF_CYC =
		(`PSL_CLK_HZ / `PSL_MS_PER_S) * `PSL_HALF_MS
)(
	input  wire logic clk,
	input  wire logic rst_n,
	psl_blink_if.blink bi
);
	localparam int unsigned START_H = `PSL_START_MS / `PSL_HALF_MS;
	localparam int unsigned ONE_H   = `PSL_ONE_MS / `PSL_HALF_MS;
	localparam int unsigned ZERO_H  = `PSL_ZERO_MS / `PSL_HALF_MS;
	localparam int unsigned GAP_H   = `PSL_GAP_MS / `PSL_HALF_MS;

	psl_pkg::psl_blink_state_t state_r;
	logic [31:0]               tick_cnt_r;
	logic [2:0]                half_cnt_r;
	logic [2:0]                bit_idx_r;
	logic [7:0]                code_r;
	logic                      tick;
	logic [2:0]                len;

	// ----------------------------------------
	// Half-second tick, held at zero while idle
	// ----------------------------------------
	assign tick = (tick_cnt_r == HALF_CYC - 1);

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			tick_cnt_r <= 32'h0;
		else if (state_r == psl_pkg::blk_idle || tick)
			tick_cnt_r <= 32'h0;
		else
			tick_cnt_r <= tick_cnt_r + 32'h1;
	end

	// ----------------------------------------
	// Frame sequencer
	// ----------------------------------------
	always_comb
	begin
		unique case (state_r)
			psl_pkg::blk_start:   len = 3'(START_H);
			psl_pkg::blk_bit_on:  len = code_r[bit_idx_r] ? 3'(ONE_H) : 3'(ZERO_H);
			psl_pkg::blk_bit_gap: len = 3'(GAP_H);
			psl_pkg::blk_idle:    len = 3'h1;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_r    <= psl_pkg::blk_idle;
			half_cnt_r <= 3'h0;
			bit_idx_r  <= 3'h0;
			code_r     <= `PSL_NO_CODE;
		end
		else if (!bi.run)
			state_r <= psl_pkg::blk_idle;
		else if (state_r == psl_pkg::blk_idle)
		begin
			state_r    <= psl_pkg::blk_start;
			half_cnt_r <= 3'h0;
			code_r     <= bi.code;
		end
		else if (tick && half_cnt_r != len - 3'h1)
			half_cnt_r <= half_cnt_r + 3'h1;
		else if (tick)
		begin
			half_cnt_r <= 3'h0;
			unique case (state_r)
				psl_pkg::blk_start:
				begin
					state_r   <= psl_pkg::blk_bit_on;
					bit_idx_r <= 3'h0;
				end
				psl_pkg::blk_bit_on:
				begin
					// Last bit leads straight into the next frame's start gap
					if (bit_idx_r == 3'(`PSL_CODE_BITS - 1))
					begin
						state_r <= psl_pkg::blk_start;
						code_r  <= bi.code;
					end
					else
						state_r <= psl_pkg::blk_bit_gap;
				end
				psl_pkg::blk_bit_gap:
				begin
					state_r   <= psl_pkg::blk_bit_on;
					bit_idx_r <= bit_idx_r + 3'h1;
				end
				psl_pkg::blk_idle:
					state_r <= psl_pkg::blk_idle;
			endcase
		end
	end

	assign bi.led_on = (state_r == psl_pkg::blk_bit_on);

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	sequence s_bit_end;
		state_r == psl_pkg::blk_bit_on && tick && half_cnt_r == len - 3'h1;
	endsequence

	a_start_dark: assert property (@(posedge clk) disable iff (!rst_n)
		state_r == psl_pkg::blk_start |-> !bi.led_on)
		else $error("led lit during start gap");

	a_one_long: assert property (@(posedge clk) disable iff (!rst_n)
		(state_r == psl_pkg::blk_bit_on && tick && half_cnt_r == 3'h0
		&& code_r[bit_idx_r] && bi.run) |=> bi.led_on && half_cnt_r == 3'h1)
		else $error("one bit ended after half second");

	a_bit_gap: assert property (@(posedge clk) disable iff (!rst_n)
		(s_bit_end and (bit_idx_r != 3'h7 && bi.run)) |=>
		state_r == psl_pkg::blk_bit_gap && !bi.led_on)
		else $error("no dark gap between bits");

	a_lsb_first: assert property (@(posedge clk) disable iff (!rst_n)
		(state_r == psl_pkg::blk_start && tick && half_cnt_r == len - 3'h1
		&& bi.run) |=> bit_idx_r == 3'h0 && bi.led_on)
		else $error("frame did not start at bit zero");
endmodule

// ---- hdl/psl_status_top.sv ----
// Power status indicator: battery and external power LEDs with fault codes.
// Assumes all status inputs are asynchronous levels from the supply monitor.
//
// What this block does
// - Battery LED steady orange in quick charge, dark with no listed state.
// - Battery LED steady green when battery full and adaptor present.
// - Low charge on battery blinks battery LED orange, equal on and off.
// - Power press after low-battery hibernation flashes battery LED orange.
// - External LED steady green while adaptor delivers DC power.
// - External LED dark with neither adaptor power nor a malfunction.
// - Malfunction blinks external LED orange, carrying the fault code.
// - Each code frame opens with two seconds dark, then eight bits.
// - A one is lit one second, a zero lit half a second.
// - Half a second dark between consecutive bit pulses.
// - Code bits go out least significant first.
// - DC input path faults use codes 10h to 1Fh.
// - First battery faults use codes 20h to 2Fh.
// - Second battery faults use codes 30h to 3Fh.
// - Powered rail faults use 40h to EFh, upper nibble picks rail.
// - DC input codes 10h to 14h, one per input fault kind.
// - First battery codes 21h to 25h, one per battery fault kind.
// - Reserved overvoltage codes 20h and 30h are never sent.
// - Second battery codes 31h to 35h, one per fault kind.
// - Low standby rail is 40h at power on or off, 45h at boot.
// - Main five volt rail uses 50h for overvoltage, 51h to 55h else.
// - Main three volt rail uses 60h for overvoltage, 61h to 65h else.
// - Channel zero core rail uses 70h to 73h.
`timescale 1ns/10ps
`include "psl_regs.svh"

module psl_status_top #(
	parameter int unsigned HALF_CYC =
		(`PSL_CLK_HZ / `PSL_MS_PER_S) * `PSL_HALF_MS
)(
	input  wire logic        clk,
	input  wire logic        nrst,
	input  wire logic        quick_charge,
	input  wire logic        battery_full,
	input  wire logic        adaptor_present,
	input  wire logic        on_battery,
	input  wire logic        battery_low,
	input  wire logic        hibernated,
	input  wire logic        power_button,
	input  wire logic [32:0] fault_cond,
	input  wire logic        fault_clear,
	output logic             bat_green,
	output logic             bat_orange,
	output logic             ext_green,
	output logic             ext_orange,
	output logic             fault_active,
	output logic [7:0]       fault_code
);
	localparam int unsigned NIN = `PSL_NUM_FAULTS + 8;

	logic                      rst_meta_r;
	logic                      rst_n;
	logic [NIN-1:0]            in_meta_r;
	logic [NIN-1:0]            in_sync_r;
	logic [`PSL_NUM_FAULTS-1:0] s_fault;
	logic                      s_qc;
	logic                      s_full;
	logic                      s_adapt;
	logic                      s_onbat;
	logic                      s_low;
	logic                      s_hib;
	logic                      s_btn;
	logic                      s_clear;
	logic                      btn_prev_r;
	logic                      btn_press;
	logic [31:0]               half_cnt_r;
	logic                      half_tick;
	logic                      blink_phase_r;
	logic [4:0]                flash_left_r;
	logic                      fault_lat_r;
	logic [7:0]                code_r;
	logic                      any_fault;
	logic [7:0]                new_code;
	psl_pkg::psl_bat_mode_t    bat_mode;

	psl_blink_if blk ();

	// ----------------------------------------
	// Reset release and input synchronisers
	// ----------------------------------------
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			rst_meta_r <= 1'b0;
			rst_n      <= 1'b0;
		end
		else
		begin
			rst_meta_r <= 1'b1;
			rst_n      <= rst_meta_r;
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			in_meta_r <= '0;
			in_sync_r <= '0;
		end
		else
		begin
			in_meta_r <= {fault_clear, power_button, hibernated, battery_low,
				on_battery, adaptor_present, battery_full, quick_charge,
				fault_cond};
			in_sync_r <= in_meta_r;
		end
	end

	assign s_fault = in_sync_r[`PSL_NUM_FAULTS-1:0];
	assign s_qc    = in_sync_r[`PSL_NUM_FAULTS];
	assign s_full  = in_sync_r[`PSL_NUM_FAULTS+1];
	assign s_adapt = in_sync_r[`PSL_NUM_FAULTS+2];
	assign s_onbat = in_sync_r[`PSL_NUM_FAULTS+3];
	assign s_low   = in_sync_r[`PSL_NUM_FAULTS+4];
	assign s_hib   = in_sync_r[`PSL_NUM_FAULTS+5];
	assign s_btn   = in_sync_r[`PSL_NUM_FAULTS+6];
	assign s_clear = in_sync_r[`PSL_NUM_FAULTS+7];

	// ----------------------------------------
	// Half-second timebase for battery patterns
	// ----------------------------------------
	assign half_tick = (half_cnt_r == HALF_CYC - 1);

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			half_cnt_r <= 32'h0;
		else if (half_tick)
			half_cnt_r <= 32'h0;
		else
			half_cnt_r <= half_cnt_r + 32'h1;
	end

	// Equal halves of on and off
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			blink_phase_r <= 1'b0;
		else if (half_tick)
			blink_phase_r <= !blink_phase_r;
	end

	// ----------------------------------------
	// Flash after press from hibernation
	// ----------------------------------------
	assign btn_press = s_btn && !btn_prev_r;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			btn_prev_r <= 1'b0;
		else
			btn_prev_r <= s_btn;
	end

	// A fixed burst of short flashes, not a steady pattern
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			flash_left_r <= 5'h0;
		else if (btn_press && s_hib)
			flash_left_r <= 5'(`PSL_FLASH_PERIOD * `PSL_FLASH_REPEAT);
		else if (half_tick && flash_left_r != 5'h0)
			flash_left_r <= flash_left_r - 5'h1;
	end

	// ----------------------------------------
	// Fault condition to code
	// ----------------------------------------
	function automatic logic [7:0] code_of(input int unsigned i);
		logic [7:0] k;
		k = 8'(i);
		if (i < `PSL_IDX_BAT1)
			code_of = `PSL_DCIN_BASE + k;
		else if (i < `PSL_IDX_BAT2)
			code_of = `PSL_BAT1_BASE + k - 8'(`PSL_IDX_BAT1);
		else if (i < `PSL_IDX_STBY_ON)
			code_of = `PSL_BAT2_BASE + k - 8'(`PSL_IDX_BAT2);
		else if (i == `PSL_IDX_STBY_ON)
			code_of = `PSL_STBY_ON_CODE;
		else if (i == `PSL_IDX_STBY_BOOT)
			code_of = `PSL_STBY_BOOT_CODE;
		else if (i < `PSL_IDX_THREE)
			code_of = `PSL_FIVE_BASE + k - 8'(`PSL_IDX_FIVE);
		else if (i < `PSL_IDX_CORE0)
			code_of = `PSL_THREE_BASE + k - 8'(`PSL_IDX_THREE);
		else
			code_of = `PSL_CORE0_BASE + k - 8'(`PSL_IDX_CORE0);
	endfunction

	// Lowest index wins; the reserved codes have no condition at all
	always_comb
	begin
		any_fault = 1'b0;
		new_code  = `PSL_NO_CODE;
		for (int i = `PSL_NUM_FAULTS - 1; i >= 0; i--)
		begin
			if (s_fault[i])
			begin
				any_fault = 1'b1;
				new_code  = code_of(i);
			end
		end
	end

	// First fault is kept until cleared; a fault in the clear cycle wins
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			fault_lat_r <= 1'b0;
			code_r      <= `PSL_NO_CODE;
		end
		else if ((!fault_lat_r || s_clear) && any_fault)
		begin
			fault_lat_r <= 1'b1;
			code_r      <= new_code;
		end
		else if (s_clear)
			fault_lat_r <= 1'b0;
	end

	assign blk.run  = fault_lat_r;
	assign blk.code = code_r;

	psl_code_blinker #(
		.HALF_CYC (HALF_CYC)
	) u_blinker (
		.clk   (clk),
		.rst_n (rst_n),
		.bi    (blk)
	);

	// ----------------------------------------
	// Battery indicator
	// ----------------------------------------
	always_comb
	begin
		if (flash_left_r != 5'h0)
			bat_mode = psl_pkg::bat_flash;
		else if (s_low && s_onbat)
			bat_mode = psl_pkg::bat_blink;
		else if (s_qc)
			bat_mode = psl_pkg::bat_orange;
		else if (s_full && s_adapt)
			bat_mode = psl_pkg::bat_green;
		else
			bat_mode = psl_pkg::bat_dark;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			bat_green  <= 1'b0;
			bat_orange <= 1'b0;
		end
		else
		begin
			bat_green <= (bat_mode == psl_pkg::bat_green);
			unique case (bat_mode)
				psl_pkg::bat_flash:
					bat_orange <= (flash_left_r[1:0] == 2'h0);
				psl_pkg::bat_blink:
					bat_orange <= blink_phase_r;
				psl_pkg::bat_orange:
					bat_orange <= 1'b1;
				default:
					bat_orange <= 1'b0;
			endcase
		end
	end

	// ----------------------------------------
	// External power indicator
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ext_green    <= 1'b0;
			ext_orange   <= 1'b0;
			fault_active <= 1'b0;
			fault_code   <= `PSL_NO_CODE;
		end
		else
		begin
			ext_green    <= s_adapt && !fault_lat_r;
			ext_orange   <= fault_lat_r && blk.led_on;
			fault_active <= fault_lat_r;
			fault_code   <= code_r;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	sequence s_faulted;
		fault_lat_r && !s_clear;
	endsequence

	a_fault_over_green: assert property (@(posedge clk) disable iff (!rst_n)
		fault_lat_r |=> !ext_green)
		else $error("green shown during a fault");

	a_ext_green_on: assert property (@(posedge clk) disable iff (!rst_n)
		(s_adapt && !fault_lat_r) |=> ext_green && !ext_orange)
		else $error("adaptor power not shown green");

	a_ext_dark_idle: assert property (@(posedge clk) disable iff (!rst_n)
		(!s_adapt && !fault_lat_r) |=> !ext_green && !ext_orange)
		else $error("external led lit with nothing to show");

	a_ext_code_blink: assert property (@(posedge clk) disable iff (!rst_n)
		(fault_lat_r && blk.led_on) |=> ext_orange)
		else $error("code pulse not on external led");

	a_code_no_rsvd: assert property (@(posedge clk) disable iff (!rst_n)
		fault_lat_r |-> code_r != `PSL_RSVD_BAT1 && code_r != `PSL_RSVD_BAT2)
		else $error("reserved code latched");

	a_code_range: assert property (@(posedge clk) disable iff (!rst_n)
		fault_lat_r |-> code_r >= `PSL_DCIN_BASE && code_r <= `PSL_CORE0_LAST)
		else $error("code outside fault ranges");

	a_latch_hold: assert property (@(posedge clk) disable iff (!rst_n)
		s_faulted |=> fault_lat_r && $stable(code_r))
		else $error("latched fault changed without clear");

	a_bat_green_full: assert property (@(posedge clk) disable iff (!rst_n)
		(s_full && s_adapt && !s_qc && !(s_low && s_onbat)
		&& flash_left_r == 5'h0) |=> bat_green && !bat_orange)
		else $error("full battery not shown green");

	a_bat_qc_orange: assert property (@(posedge clk) disable iff (!rst_n)
		(s_qc && !(s_low && s_onbat) && flash_left_r == 5'h0)
		|=> bat_orange && !bat_green)
		else $error("quick charge not steady orange");

	a_flash_load: assert property (@(posedge clk) disable iff (!rst_n)
		(btn_press && s_hib) |=> flash_left_r != 5'h0)
		else $error("press after hibernation gave no flash");
endmodule

// ---- test/psl_led_observer.sv ----
// LED observer: decodes the fault blink pattern the way a technician reads it.
// Assumes the indicator is sampled on the block clock and rearmed before use.
`timescale 1ns/10ps

module psl_led_observer #(
	parameter int unsigned HALF_CYC = 4
)(
	input  wire logic   clk,
	input  wire logic   rearm,
	input  wire logic   led,
	output logic [7:0]  code,
	output int unsigned frames,
	output int unsigned bad
);
	logic        led_q;
	logic        bit_v;
	logic [7:0]  shift;
	int unsigned run;
	int unsigned idx;

	// ----------------
	// Run length decoding
	// ----------------
	// Long dark allowed only before the first frame; repeats must be exact
	always @(posedge clk)
	begin
		if (rearm)
		begin
			frames <= 0;
			bad <= 0;
			idx <= 8;
			run <= 1;
			led_q <= led;
		end
		else if (led === led_q)
			run <= run + 1;
		else
		begin
			led_q <= led;
			run <= 1;
			if (led === 1'b1 && idx == 8)
			begin
				if (run == 4 * HALF_CYC || (frames == 0 && run > 4 * HALF_CYC))
					idx <= 0;
				else
					bad <= bad + 1;
			end
			else if (led === 1'b1 && run != HALF_CYC)
				bad <= bad + 1;
			else if (led !== 1'b1 && idx < 8)
			begin
				bit_v = (run == 2 * HALF_CYC);
				if (run != HALF_CYC && !bit_v)
					bad <= bad + 1;
				shift <= {bit_v, shift[7:1]};
				idx <= idx + 1;
				if (idx == 7)
				begin
					code <= {bit_v, shift[7:1]};
					frames <= frames + 1;
				end
			end
			else if (led !== 1'b1)
				bad <= bad + 1;
		end
	end
endmodule

// ---- test/testbench.sv ----
// Testbench: drives status levels and faults, checks both indicators.
// Assumes the observer decodes the external indicator blink pattern.
`timescale 1ns/10ps

`define CHK(name, exp, got) \
	begin \
		checks++; \
		if ((got) !== (exp)) \
		begin \
			num_errors++; \
			$display("Error %s expected %h seen %h", name, exp, got); \
		end \
	end

module testbench;
	// Short half period keeps each frame near a hundred cycles
	localparam int unsigned H = 4;

	logic        clk;
	logic        nrst;
	logic        quick_charge;
	logic        battery_full;
	logic        adaptor_present;
	logic        on_battery;
	logic        battery_low;
	logic        hibernated;
	logic        power_button;
	logic [32:0] fault_cond;
	logic        fault_clear;
	logic        bat_green;
	logic        bat_orange;
	logic        ext_green;
	logic        ext_orange;
	logic        fault_active;
	logic [7:0]  fault_code;
	logic        rearm;
	logic [7:0]  obs_code;
	logic [7:0]  ecode;
	int unsigned obs_frames;
	int unsigned obs_bad;
	int unsigned num_errors;
	int unsigned checks;
	int unsigned hi;
	int unsigned lo;
	int          fidx [14] = '{0, 4, 5, 9, 10, 14, 15, 16, 17, 22, 23, 28, 29, 32};

	psl_status_top #(.HALF_CYC(H)) psl_status_top_inst (.clk(clk), .nrst(nrst),
		.quick_charge(quick_charge), .battery_full(battery_full),
		.adaptor_present(adaptor_present), .on_battery(on_battery),
		.battery_low(battery_low), .hibernated(hibernated),
		.power_button(power_button), .fault_cond(fault_cond),
		.fault_clear(fault_clear), .bat_green(bat_green),
		.bat_orange(bat_orange), .ext_green(ext_green),
		.ext_orange(ext_orange), .fault_active(fault_active),
		.fault_code(fault_code));

	psl_led_observer #(.HALF_CYC(H)) psl_led_observer_inst (.clk(clk),
		.rearm(rearm), .led(ext_orange), .code(obs_code),
		.frames(obs_frames), .bad(obs_bad));

	always #50 clk = ~clk;

	// ----------------
	// Access tasks
	// ----------------
	task automatic cyc(input int unsigned n);
		repeat (n) @(posedge clk);
	endtask

	// Order: quick, full, adaptor, on battery, low, hibernated
	task automatic set_status(input logic [5:0] v);
		@(posedge clk);
		{quick_charge, battery_full, adaptor_present, on_battery, battery_low,
			hibernated} <= v;
		cyc(6);
	endtask

	task automatic wait_led(input logic v, output int unsigned n);
		n = 0;
		while (bat_orange !== v && n < 1000)
		begin
			@(posedge clk);
			n++;
		end
	endtask

	task automatic press_count(output int unsigned n);
		logic p;
		@(posedge clk);
		power_button <= 1'b1;
		cyc(2);
		power_button <= 1'b0;
		n = 0;
		p = bat_orange;
		repeat (20 * H)
		begin
			@(posedge clk);
			if (bat_orange === 1'b1 && p !== 1'b1)
				n++;
			p = bat_orange;
		end
	endtask

	task automatic clear_fault;
		@(posedge clk);
		fault_cond <= 33'h000000000;
		fault_clear <= 1'b1;
		cyc(4);
		fault_clear <= 1'b0;
		cyc(4);
	endtask

	function automatic logic [7:0] exp_code(input int i);
		if (i < 5)
			return 8'h10 + 8'(i);
		if (i < 10)
			return 8'h21 + 8'(i - 5);
		if (i < 15)
			return 8'h31 + 8'(i - 10);
		if (i < 17)
			return (i == 15) ? 8'h40 : 8'h45;
		if (i < 23)
			return 8'h50 + 8'(i - 17);
		if (i < 29)
			return 8'h60 + 8'(i - 23);
		return 8'h70 + 8'(i - 29);
	endfunction

	task automatic give_verdict;
		$display("Comparisons %0d, mismatches %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// ----------------
	// Tests
	// ----------------
	initial
	begin
		clk = 1'b0;
		nrst = 1'b0;
		{quick_charge, battery_full, adaptor_present} = 3'h0;
		{on_battery, battery_low, hibernated, power_button} = 4'h0;
		fault_cond = 33'h000000000;
		fault_clear = 1'b0;
		rearm = 1'b0;
		num_errors = 0;
		checks = 0;
		cyc(8);
		`CHK("reset outputs", 13'h0000, {bat_green, bat_orange, ext_green,
			ext_orange, fault_active, fault_code})
		nrst <= 1'b1;
		set_status(6'h00);
		`CHK("dark battery", 2'h0, {bat_green, bat_orange})
		`CHK("dark external", 2'h0, {ext_green, ext_orange})
		set_status(6'h20);
		`CHK("quick charge", 2'h1, {bat_green, bat_orange})
		set_status(6'h18);
		`CHK("full on adaptor", 2'h2, {bat_green, bat_orange})
		`CHK("adaptor power", 2'h2, {ext_green, ext_orange})
		set_status(6'h10);
		`CHK("full no adaptor", 2'h0, {bat_green, bat_orange})
		set_status(6'h06);
		wait_led(1'b0, hi);
		wait_led(1'b1, hi);
		wait_led(1'b0, hi);
		wait_led(1'b1, lo);
		`CHK("blink on time", H, hi)
		`CHK("blink off time", H, lo)
		set_status(6'h00);
		press_count(hi);
		`CHK("press ignored", 0, hi)
		set_status(6'h01);
		press_count(hi);
		`CHK("flash count", 4, hi)
		set_status(6'h08);
		foreach (fidx[k])
		begin
			ecode = exp_code(fidx[k]);
			@(posedge clk);
			rearm <= 1'b1;
			@(posedge clk);
			rearm <= 1'b0;
			fault_cond <= 33'h000000001 << fidx[k];
			cyc(6);
			`CHK("latched", 1'b1, fault_active)
			`CHK("fault code", ecode, fault_code)
			`CHK("code group", ecode[7:4], fault_code[7:4])
			`CHK("reserved code", 1'b0, fault_code[3:0] == 4'h0 &&
				(fault_code[7:4] == 4'h2 || fault_code[7:4] == 4'h3))
			`CHK("green overridden", 1'b0, ext_green)
			hi = 0;
			while (obs_frames < 2 && hi < 1000)
			begin
				@(posedge clk);
				hi++;
			end
			`CHK("frames repeated", 1'b1, obs_frames >= 2)
			`CHK("frame timing", 0, obs_bad)
			`CHK("blinked code", ecode, obs_code)
			clear_fault();
			`CHK("cleared", 3'h4, {ext_green, ext_orange, fault_active})
		end
		fault_cond <= 33'h020000000;
		cyc(6);
		fault_cond <= 33'h020000001;
		cyc(6);
		`CHK("later fault ignored", 8'h70, fault_code)
		// Clear while a fault still stands: the set wins, lowest index taken
		fault_clear <= 1'b1;
		cyc(4);
		fault_clear <= 1'b0;
		cyc(6);
		`CHK("set wins over clear", 8'h10, fault_code)
		`CHK("still latched", 1'b1, fault_active)
		clear_fault();
		fault_cond <= 33'h020000020;
		cyc(6);
		`CHK("lowest index wins", 8'h21, fault_code)
		clear_fault();
		give_verdict();
	end

	// Span well beyond the expected run of about three thousand cycles
	initial
	begin
		#3000000;
		num_errors++;
		give_verdict();
	end
endmodule
